/* File: icache_bus_master.sv */
// Single-word memory bus master used for fills and set dumps
`default_nettype none
module icache_bus_master (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	icache_mem_if.master     link,
	output var  logic        mem_req,
	output var  logic        mem_we,
	output var  logic [31:0] mem_addr,
	output var  logic [31:0] mem_wdata,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        mem_ack
);
	logic        done_reg;
	logic [31:0] rdata_reg;

	assign link.done  = done_reg;
	assign link.rdata = rdata_reg;

	// Request stays up until the memory acknowledges it
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_addr  <= 32'h00000000;
			mem_wdata <= 32'h00000000;
			done_reg  <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			done_reg <= 1'b0;
			if (mem_req) begin
				if (mem_ack) begin
					mem_req   <= 1'b0;
					done_reg  <= 1'b1;
					rdata_reg <= mem_rdata;
				end
			end else if (link.start) begin
				mem_req   <= 1'b1;
				mem_we    <= link.we;
				mem_addr  <= link.addr;
				mem_wdata <= link.wdata;
			end
		end
	end
endmodule // icache_bus_master
`default_nettype wire

/* File: icache_control_unit.sv */
// Instruction-cache control unit: command decode, storage, dump, status
`default_nettype none
module icache_control_unit #(
	parameter int SETS = icache_pkg::DEFAULT_SETS,
	parameter int WAYS = icache_pkg::DEFAULT_WAYS
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        cmd_valid,
	input  wire logic [31:0] function_select_operand,
	input  wire logic [31:0] address_operand,
	input  wire logic [31:0] param_operand,
	output var  logic        busy,
	output var  logic        cmd_done,
	output var  logic        result_valid,
	output var  logic [31:0] result_data,
	output var  logic        fault_invalid_operand,
	input  wire logic        fetch_req,
	input  wire logic [31:0] fetch_addr,
	output var  logic        fetch_hit,
	output var  logic [31:0] fetch_data,
	output var  logic        mem_req,
	output var  logic        mem_we,
	output var  logic [31:0] mem_addr,
	output var  logic [31:0] mem_wdata,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        mem_ack,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [31:0] reg_rdata,
	output var  logic        irq
);
	// ****************************************************************
	// Geometry
	// ****************************************************************
	localparam int SB        = $clog2(SETS);
	localparam int TAGW      = 28 - SB;
	localparam int FILL_LAST = SETS * icache_pkg::WORDS_PER_LINE - 1;
	localparam int SLOT_LAST = icache_pkg::SLOTS_PER_WAY * WAYS;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_FILL_REQ  = 3'b001,
		ST_FILL_WAIT = 3'b010,
		ST_DUMP_REQ  = 3'b011,
		ST_DUMP_WAIT = 3'b100
	} state_t;

	state_t      state_reg;
	logic        enabled_reg;
	logic        locked_reg;
	logic [31:0] cur_addr_reg;
	logic [15:0] count_reg;
	logic [SB-1:0] set_idx_reg;
	logic [SB-1:0] end_set_reg;
	logic [7:0]  slot_reg;
	logic        mstart_reg;
	logic        mwe_reg;
	logic [31:0] mwdata_reg;
	logic [1:0]  irq_status_reg;
	logic [1:0]  irq_mask_reg;
	logic [1:0]  irq_status_next;

	logic [TAGW-1:0] tag_mem   [SETS][WAYS];
	logic [3:0]      valid_mem [SETS][WAYS];
	logic [31:0]     data_mem  [SETS][WAYS][4];

	logic        cmd_take;
	logic [7:0]  fn;
	logic        fill_word;
	logic        inval_all;
	logic [15:0] dump_start;
	logic [15:0] dump_end;
	logic [31:0] geometry_word;
	logic [31:0] lock_word;
	logic [31:0] dump_word;
	logic [SB-1:0] fill_set;
	logic [1:0]  fill_wsel;

	icache_mem_if mif ();

	assign mif.start = mstart_reg;
	assign mif.we    = mwe_reg;
	assign mif.addr  = cur_addr_reg;
	assign mif.wdata = mwdata_reg;

	icache_bus_master u_master (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.link      (mif.master),
		.mem_req   (mem_req),
		.mem_we    (mem_we),
		.mem_addr  (mem_addr),
		.mem_wdata (mem_wdata),
		.mem_rdata (mem_rdata),
		.mem_ack   (mem_ack)
	);

	// ****************************************************************
	// Decode and status words
	// ****************************************************************
	always_comb begin
		fn        = function_select_operand[7:0];
		cmd_take  = cmd_valid && (state_reg == ST_IDLE);
		fill_word = (state_reg == ST_FILL_WAIT) && mif.done;
		inval_all = cmd_take && ((fn == icache_pkg::FN_INVALIDATE) ||
			(fn == icache_pkg::FN_LOAD_LOCK));
		fill_set  = cur_addr_reg[4 +: SB];
		fill_wsel = cur_addr_reg[3:2];
		dump_start = param_operand[15:0];
		// Clamp keeps the walk inside the array for any end value
		if (param_operand[31:16] >= 16'(SETS)) begin
			dump_end = 16'(SETS - 1);
		end else begin
			dump_end = param_operand[31:16];
		end
	end

	always_comb begin
		geometry_word = 32'h00000000;
		geometry_word[icache_pkg::GEO_EN_BIT] = enabled_reg;
		geometry_word[icache_pkg::GEO_BYTES_LSB +: 4] =
			icache_pkg::BYTES_ATOM_LOG2;
		geometry_word[icache_pkg::GEO_ATOMS_LSB +: 4] =
			icache_pkg::ATOMS_LINE_LOG2;
		geometry_word[icache_pkg::GEO_SETS_LSB +: 4] = 4'(SB);
		geometry_word[icache_pkg::GEO_WAYS_LSB +: 12] = 12'(WAYS - 1);
		lock_word = 32'h00000000;
		lock_word[icache_pkg::LCK_BLOCKS_LSB +: 8] = icache_pkg::LOCK_BLOCKS;
		lock_word[icache_pkg::LCK_SIZE_LSB +: 16] =
			16'(SETS * icache_pkg::WORDS_PER_LINE);
		lock_word[icache_pkg::LCK_COUNT_LSB +: 8] = {7'h00, locked_reg};
	end

	// Word emitted at each slot of a dumped set
	always_comb begin
		int base;
		base      = 0;
		dump_word = {31'h0, locked_reg};
		for (int w = 0; w < WAYS; w++) begin
			base = 1 + icache_pkg::SLOTS_PER_WAY * w;
			if (int'(slot_reg) == base) begin
				dump_word = 32'(tag_mem[set_idx_reg][w]);
			end else if (int'(slot_reg) == base + 1) begin
				dump_word = {28'h0000000, valid_mem[set_idx_reg][w]};
			end
			for (int k = 0; k < 4; k++) begin
				if (int'(slot_reg) == base + 2 + k) begin
					dump_word = data_mem[set_idx_reg][w][k];
				end
			end
		end
	end

	// ****************************************************************
	// Command sequencer
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_reg             <= ST_IDLE;
			enabled_reg           <= 1'b0;
			locked_reg            <= 1'b0;
			cur_addr_reg          <= 32'h00000000;
			count_reg             <= 16'h0000;
			set_idx_reg           <= '0;
			end_set_reg           <= '0;
			slot_reg              <= 8'h00;
			mstart_reg            <= 1'b0;
			mwe_reg               <= 1'b0;
			mwdata_reg            <= 32'h00000000;
			cmd_done              <= 1'b0;
			result_valid          <= 1'b0;
			result_data           <= 32'h00000000;
			fault_invalid_operand <= 1'b0;
			busy                  <= 1'b0;
		end else begin
			cmd_done              <= 1'b0;
			result_valid          <= 1'b0;
			fault_invalid_operand <= 1'b0;
			mstart_reg            <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (cmd_take) begin
						// Operands not listed per selector are never latched
						case (fn)
							icache_pkg::FN_DISABLE: begin
								enabled_reg <= 1'b0;
								cmd_done    <= 1'b1;
							end
							icache_pkg::FN_ENABLE: begin
								enabled_reg <= 1'b1;
								cmd_done    <= 1'b1;
							end
							icache_pkg::FN_INVALIDATE: begin
								locked_reg <= 1'b0;
								cmd_done   <= 1'b1;
							end
							icache_pkg::FN_LOAD_LOCK: begin
								locked_reg   <= 1'b0;
								cur_addr_reg <= address_operand &
									icache_pkg::ALIGN_MASK;
								count_reg    <= 16'h0000;
								// Only one block can lock; any nonzero count fills it
								if (param_operand == 32'h00000000) begin
									cmd_done <= 1'b1;
								end else begin
									state_reg <= ST_FILL_REQ;
									busy      <= 1'b1;
								end
							end
							icache_pkg::FN_GEOMETRY: begin
								result_data  <= geometry_word;
								result_valid <= 1'b1;
								cmd_done     <= 1'b1;
							end
							icache_pkg::FN_LOCK_STATUS: begin
								result_data  <= lock_word;
								result_valid <= 1'b1;
								cmd_done     <= 1'b1;
							end
							icache_pkg::FN_STORE_SETS: begin
								if (dump_start > dump_end) begin
									fault_invalid_operand <= 1'b1;
									cmd_done              <= 1'b1;
								end else begin
									set_idx_reg  <= dump_start[SB-1:0];
									end_set_reg  <= dump_end[SB-1:0];
									slot_reg     <= 8'h00;
									cur_addr_reg <= address_operand;
									state_reg    <= ST_DUMP_REQ;
									busy         <= 1'b1;
								end
							end
							default: begin
								fault_invalid_operand <= 1'b1;
								cmd_done              <= 1'b1;
							end
						endcase
					end
				end
				ST_FILL_REQ: begin
					mstart_reg <= 1'b1;
					mwe_reg    <= 1'b0;
					state_reg  <= ST_FILL_WAIT;
				end
				ST_FILL_WAIT: begin
					if (mif.done) begin
						if (count_reg == 16'(FILL_LAST)) begin
							locked_reg <= 1'b1;
							cmd_done   <= 1'b1;
							busy       <= 1'b0;
							state_reg  <= ST_IDLE;
						end else begin
							count_reg    <= count_reg + 16'h0001;
							cur_addr_reg <= cur_addr_reg + icache_pkg::WORD_STEP;
							state_reg    <= ST_FILL_REQ;
						end
					end
				end
				ST_DUMP_REQ: begin
					mstart_reg <= 1'b1;
					mwe_reg    <= 1'b1;
					mwdata_reg <= dump_word;
					state_reg  <= ST_DUMP_WAIT;
				end
				ST_DUMP_WAIT: begin
					if (mif.done) begin
						cur_addr_reg <= cur_addr_reg + icache_pkg::WORD_STEP;
						state_reg    <= ST_DUMP_REQ;
						if (slot_reg == 8'(SLOT_LAST)) begin
							slot_reg <= 8'h00;
							if (set_idx_reg == end_set_reg) begin
								cmd_done  <= 1'b1;
								busy      <= 1'b0;
								state_reg <= ST_IDLE;
							end else begin
								set_idx_reg <= set_idx_reg + SB'(1);
							end
						end else begin
							slot_reg <= slot_reg + 8'h01;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					busy      <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// Cache storage
	// ****************************************************************
	// Lock fills go to way 0 only, so locked code never shares a way
	always_ff @(posedge ref_clk) begin
		if (srst || inval_all) begin
			for (int s = 0; s < SETS; s++) begin
				for (int w = 0; w < WAYS; w++) begin
					valid_mem[s][w] <= 4'h0;
				end
			end
		end else if (fill_word) begin
			tag_mem[fill_set][0]             <= cur_addr_reg[31:4+SB];
			valid_mem[fill_set][0][fill_wsel] <= 1'b1;
			data_mem[fill_set][0][fill_wsel]  <= mif.rdata;
		end
	end

	// Lookups miss while an operation runs, stalling fetch behind it
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fetch_hit  <= 1'b0;
			fetch_data <= 32'h00000000;
		end else begin
			fetch_hit <= 1'b0;
			if (fetch_req && enabled_reg && (state_reg == ST_IDLE)) begin
				for (int w = 0; w < WAYS; w++) begin
					if (valid_mem[fetch_addr[4 +: SB]][w][fetch_addr[3:2]] &&
						(tag_mem[fetch_addr[4 +: SB]][w] ==
						fetch_addr[31:4+SB])) begin
						fetch_hit  <= 1'b1;
						fetch_data <= data_mem[fetch_addr[4 +: SB]][w]
							[fetch_addr[3:2]];
					end
				end
			end
		end
	end

	// ****************************************************************
	// Software registers and interrupt
	// ****************************************************************
	always_comb begin
		irq_status_next = irq_status_reg;
		if (reg_wr && (reg_addr == icache_pkg::REG_IRQ_STATUS)) begin
			irq_status_next = irq_status_reg & ~reg_wdata[1:0];
		end
		// New events win over a clear in the same cycle
		irq_status_next[icache_pkg::IRQ_DONE_BIT] =
			irq_status_next[icache_pkg::IRQ_DONE_BIT] | cmd_done;
		irq_status_next[icache_pkg::IRQ_FAULT_BIT] =
			irq_status_next[icache_pkg::IRQ_FAULT_BIT] |
			fault_invalid_operand;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_status_reg <= icache_pkg::IRQ_RESET;
			irq_mask_reg   <= icache_pkg::IRQ_RESET;
			irq            <= 1'b0;
		end else begin
			irq_status_reg <= irq_status_next;
			if (reg_wr && (reg_addr == icache_pkg::REG_IRQ_MASK)) begin
				irq_mask_reg <= reg_wdata[1:0];
			end
			irq <= |(irq_status_reg & irq_mask_reg);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= 32'h00000000;
		end else begin
			reg_rdata <= 32'h00000000;
			if (reg_rd) begin
				case (reg_addr)
					icache_pkg::REG_IRQ_STATUS:
						reg_rdata <= {30'h0, irq_status_reg};
					icache_pkg::REG_IRQ_MASK:
						reg_rdata <= {30'h0, irq_mask_reg};
					icache_pkg::REG_GEOMETRY:    reg_rdata <= geometry_word;
					icache_pkg::REG_LOCK_STATUS: reg_rdata <= lock_word;
					default:                     reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // icache_control_unit
`default_nettype wire

/* File: icache_mem_if.sv */
// Word transfer link between the control unit and its bus master
`default_nettype none
interface icache_mem_if;
	logic        start;
	logic        we;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        done;
	modport client (output start, we, addr, wdata, input rdata, done);
	modport master (input start, we, addr, wdata, output rdata, done);
endinterface
`default_nettype wire

/* File: icache_mem_model.sv */
// Memory responder with selectable ack latency and transfer log
`default_nettype none
module icache_mem_model (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        slow,
	input  wire logic        clr,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output var  logic [31:0] mem_rdata,
	output var  logic        mem_ack,
	output var  int          n_xfer,
	output var  logic [31:0] first_addr,
	output var  logic [31:0] last_addr,
	output var  logic [31:0] first_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	int wait_cnt;
	always_ff @(posedge ref_clk) begin
		mem_ack   <= 1'b0;
		// Read data is valid only in the ack cycle, so it toggles elsewhere
		mem_rdata <= ~mem_rdata;
		if (srst || clr) begin
			n_xfer    <= 0;
			wait_cnt  <= 0;
			mem_rdata <= 32'h0;
		end else if (mem_req && !mem_ack) begin
			wait_cnt <= wait_cnt + 1;
			if (wait_cnt >= (slow ? 3 : 0)) begin
				mem_ack   <= 1'b1;
				mem_rdata <= ~mem_addr;
				wait_cnt  <= 0;
				n_xfer    <= n_xfer + 1;
				last_addr <= mem_addr;
				if (n_xfer == 0) begin
					first_addr  <= mem_addr;
					first_wdata <= mem_wdata;
				end
			end
		end
	end
endmodule // icache_mem_model
`default_nettype wire

/* File: icache_monitor.sv */
// Concurrent checks on the cache control unit's ports
`default_nettype none
module icache_monitor #(
	parameter int SETS = 64,
	parameter int WAYS = 2
) (
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        cmd_valid,
	input wire logic [31:0] function_select_operand,
	input wire logic [31:0] param_operand,
	input wire logic        busy,
	input wire logic        cmd_done,
	input wire logic        result_valid,
	input wire logic [31:0] result_data,
	input wire logic        fault_invalid_operand,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic        mem_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] GEO = 32'((WAYS - 1) << 16)
		| 32'($clog2(SETS) << 12) | 32'h00000220;
	localparam logic [31:0] LCK = 32'((SETS * 4) << 8) | 32'h00000001;
	logic [7:0]  fn;
	logic        take;
	logic        have_prev;
	logic [31:0] prev_waddr;
	assign fn   = function_select_operand[7:0];
	assign take = cmd_valid && !busy;

	// Consecutive-address tracking restarts with every command
	always_ff @(posedge ref_clk) begin
		if (srst || !busy) begin
			have_prev <= 1'b0;
		end else if (mem_req && mem_we && mem_ack) begin
			have_prev  <= 1'b1;
			prev_waddr <= mem_addr;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	geo_word_ok_a: assert property (
		take && fn == 8'h04 |=> result_valid
		&& result_data[31:1] == GEO[31:1]) else $error("bad geometry");
	lock_word_ok_a: assert property (
		take && fn == 8'h05 |=> result_valid && result_data[31:25] == 7'h0
		&& result_data[23:0] == LCK[23:0]) else $error("bad lock word");
	simple_fn_done_a: assert property (
		take && fn <= 8'h02 |=> cmd_done && !fault_invalid_operand
		&& !result_valid && !busy) else $error("simple op not done");
	bad_fn_fault_a: assert property (
		take && fn > 8'h06 |=> cmd_done && fault_invalid_operand
		&& !mem_req) else $error("bad selector not faulted");
	fault_with_done_a: assert property (
		fault_invalid_operand |-> cmd_done) else $error("lone fault");
	long_op_busy_a: assert property (
		take && fn == 8'h03 && param_operand != 32'h0 |=> busy
		&& !cmd_done) else $error("fill not busy");
	req_hold_a: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
		&& $stable(mem_we) && $stable(mem_wdata)) else $error("req moved");
	req_end_a: assert property (
		mem_req && mem_ack |=> !mem_req) else $error("req after ack");
	req_in_op_a: assert property (
		mem_req |-> busy) else $error("bus use while idle");
	dump_consec_a: assert property (
		$rose(mem_req) && mem_we && have_prev
		|-> mem_addr == prev_waddr + 32'h4) else $error("gap in dump");
	fill_cov: cover property (take && fn == 8'h03);
	dump_cov: cover property (mem_req && mem_we && mem_ack);
	fault_cov: cover property (fault_invalid_operand);
	end_cov: cover property ($fell(busy));
endmodule // icache_monitor
`default_nettype wire

/* File: icache_pkg.sv */
// Shared constants for the instruction-cache control unit
`default_nettype none
package icache_pkg;
	// ****************************************************************
	// Function selector codes
	// ****************************************************************
	localparam logic [7:0] FN_DISABLE     = 8'h00;
	localparam logic [7:0] FN_ENABLE      = 8'h01;
	localparam logic [7:0] FN_INVALIDATE  = 8'h02;
	localparam logic [7:0] FN_LOAD_LOCK   = 8'h03;
	localparam logic [7:0] FN_GEOMETRY    = 8'h04;
	localparam logic [7:0] FN_LOCK_STATUS = 8'h05;
	localparam logic [7:0] FN_STORE_SETS  = 8'h06;

	// ****************************************************************
	// Geometry and lock status layout
	// ****************************************************************
	localparam int          DEFAULT_SETS    = 64;
	localparam int          DEFAULT_WAYS    = 2;
	localparam int          WORDS_PER_LINE  = 4;
	localparam int          SLOTS_PER_WAY   = 6;
	localparam logic [31:0] ALIGN_MASK      = 32'hFFFFFFF0;
	localparam logic [31:0] WORD_STEP       = 32'h00000004;
	localparam logic [3:0]  BYTES_ATOM_LOG2 = 4'h2;
	localparam logic [3:0]  ATOMS_LINE_LOG2 = 4'h2;
	localparam logic [7:0]  LOCK_BLOCKS     = 8'h01;
	localparam int          GEO_EN_BIT      = 0;
	localparam int          GEO_BYTES_LSB   = 4;
	localparam int          GEO_ATOMS_LSB   = 8;
	localparam int          GEO_SETS_LSB    = 12;
	localparam int          GEO_WAYS_LSB    = 16;
	localparam int          LCK_BLOCKS_LSB  = 0;
	localparam int          LCK_SIZE_LSB    = 8;
	localparam int          LCK_COUNT_LSB   = 24;

	// ****************************************************************
	// Software register map and interrupt bits
	// ****************************************************************
	localparam logic [7:0]  REG_IRQ_STATUS  = 8'h00;
	localparam logic [7:0]  REG_IRQ_MASK    = 8'h04;
	localparam logic [7:0]  REG_GEOMETRY    = 8'h08;
	localparam logic [7:0]  REG_LOCK_STATUS = 8'h0C;
	localparam int          IRQ_DONE_BIT    = 0;
	localparam int          IRQ_FAULT_BIT   = 1;
	localparam logic [1:0]  IRQ_RESET       = 2'h0;
endpackage
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the instruction-cache control unit
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk, srst, cmd_valid, busy, cmd_done, result_valid;
	logic        fault_invalid_operand, fetch_req, fetch_hit, mem_req;
	logic        mem_we, mem_ack, reg_wr, reg_rd, irq, slow, clr;
	logic [31:0] function_select_operand, address_operand, param_operand;
	logic [31:0] result_data, fetch_addr, fetch_data, mem_addr, mem_wdata;
	logic [31:0] mem_rdata, reg_wdata, reg_rdata;
	logic [31:0] first_addr, last_addr, first_wdata;
	logic [7:0]  reg_addr;
	int          n_xfer, n_mismatch, compares;

	icache_control_unit #(.SETS(64), .WAYS(2)) DUT (.ref_clk, .srst,
		.cmd_valid, .function_select_operand, .address_operand,
		.param_operand, .busy, .cmd_done, .result_valid, .result_data,
		.fault_invalid_operand, .fetch_req, .fetch_addr, .fetch_hit,
		.fetch_data, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
		.mem_ack, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
	icache_mem_model mem (.ref_clk, .srst, .slow, .clr, .mem_req, .mem_we,
		.mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .n_xfer, .first_addr,
		.last_addr, .first_wdata);

	// ****************************************************************
	// Access tasks
	// ****************************************************************
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] fn, input logic [31:0] a, p,
			output logic [31:0] res, output logic flt);
		int i;
		@(posedge ref_clk);
		clr                     <= 1'b1;
		cmd_valid               <= 1'b1;
		function_select_operand <= {24'h0, fn};
		address_operand         <= a;
		param_operand           <= p;
		for (i = 0; i < 5000; i++) begin
			@(posedge ref_clk);
			cmd_valid <= 1'b0;
			clr       <= 1'b0;
			#1;
			if (cmd_done === 1'b1) break;
		end
		res = result_data;
		flt = fault_invalid_operand;
		if (i == 5000) begin
			n_mismatch++;
			$display("Error at %0t: command never finished", $time);
			give_verdict();
		end
	endtask
	task automatic reg_access(input logic wr, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		reg_wr    <= wr;
		reg_rd    <= !wr;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		q = reg_rdata;
	endtask
	task automatic fetch(input logic [31:0] a, output logic h,
			output logic [31:0] q);
		@(posedge ref_clk);
		fetch_req  <= 1'b1;
		fetch_addr <= a;
		@(posedge ref_clk);
		fetch_req <= 1'b0;
		#1;
		h = fetch_hit;
		q = fetch_data;
	endtask
	task automatic settle();
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	// ****************************************************************
	// Stimulus
	// ****************************************************************
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		logic [31:0] r;
		logic        f;
		logic        h;
		{cmd_valid, fetch_req, reg_wr, reg_rd, slow, clr} = '0;
		{function_select_operand, address_operand, param_operand} = '0;
		{fetch_addr, reg_wdata, reg_addr} = '0;
		n_mismatch = 0;
		compares   = 0;
		srst       = 1'b1;
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		#1;
		check(32'({busy, cmd_done, mem_req, irq}), 32'h0);
		cmd(8'h04, 32'hFFFFFFFF, 32'h0, r, f);
		check(r, 32'h00016220);
		cmd(8'h05, 32'h0, 32'h0, r, f);
		check(r, 32'h00010001);
		cmd(8'h01, 32'h0, 32'h0, r, f);
		cmd(8'h04, 32'h0, 32'h0, r, f);
		check(r, 32'h00016221);
		cmd(8'h00, 32'hDEADBEEF, 32'h12345678, r, f);
		cmd(8'h04, 32'h0, 32'h0, r, f);
		check(r, 32'h00016220);
		cmd(8'h01, 32'h0, 32'h0, r, f);
		slow <= 1'b1;
		cmd(8'h03, 32'h00001234, 32'h1, r, f);
		check(32'(n_xfer), 32'h100);
		check(first_addr, 32'h1230);
		check(last_addr, 32'h162C);
		cmd(8'h05, 32'h0, 32'h0, r, f);
		check(r, 32'h01010001);
		fetch(32'h1238, h, r);
		check(32'(h), 32'h1);
		check(r, ~32'h1238);
		slow <= 1'b0;
		cmd(8'h06, 32'h100, 32'h0, r, f);
		check(32'(n_xfer), 32'hD);
		check(first_addr, 32'h100);
		check(last_addr, 32'h130);
		check(first_wdata, 32'h1);
		cmd(8'h06, 32'h200, 32'hFFFF003F, r, f);
		check(32'({f, n_xfer[7:0]}), 32'hD);
		cmd(8'h06, 32'h200, 32'h00020005, r, f);
		check(32'({f, n_xfer[7:0]}), 32'h100);
		cmd(8'h02, 32'h0, 32'h0, r, f);
		cmd(8'h05, 32'h0, 32'h0, r, f);
		check(r, 32'h00010001);
		fetch(32'h1238, h, r);
		check(32'(h), 32'h0);
		cmd(8'h03, 32'h00001234, 32'h0, r, f);
		check(32'({f, n_xfer[7:0]}), 32'h0);
		cmd(8'h05, 32'h0, 32'h0, r, f);
		check(r, 32'h00010001);
		reg_access(1'b1, 8'h00, 32'h3, r);
		reg_access(1'b1, 8'h04, 32'h2, r);
		cmd(8'h07, 32'h0, 32'h0, r, f);
		check(32'(f), 32'h1);
		settle();
		check(32'(irq), 32'h1);
		reg_access(1'b0, 8'h00, 32'h0, r);
		check(r, 32'h3);
		reg_access(1'b1, 8'h00, 32'h2, r);
		settle();
		check(32'(irq), 32'h0);
		cmd(8'hFF, 32'h0, 32'h0, r, f);
		check(32'(f), 32'h1);
		reg_access(1'b1, 8'h04, 32'h0, r);
		settle();
		check(32'(irq), 32'h0);
		reg_access(1'b0, 8'h08, 32'h0, r);
		check(r, 32'h00016221);
		reg_access(1'b0, 8'h10, 32'h0, r);
		check(r, 32'h0);
		give_verdict();
	end
endmodule // tb_top

bind icache_control_unit icache_monitor #(.SETS(SETS), .WAYS(WAYS)) mon (
	.ref_clk, .srst, .cmd_valid, .function_select_operand, .param_operand,
	.busy, .cmd_done, .result_valid, .result_data, .fault_invalid_operand,
	.mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack);
`default_nettype wire
